// >>> verilog/bt8_timer.sv
// 8-bit auto-reload basic timer with slave controller and Wishbone slave
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/10ps
module bt8_timer
  import bt8_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              internal_trigger_one_i,
  input  wire logic              internal_trigger_three_i,
  output logic                   trigger_output_o,
  output logic                   update_irq_o,
  output logic                   trigger_irq_o
);

  function automatic logic [PSC_CW-1:0] psc_mask(input logic [PSC_SW-1:0] s);
    psc_mask = PSC_CW'((8'h01 << s) - 8'h01);
  endfunction : psc_mask

  logic [IDX_W-1:0]  idx;
  logic              adr_ok;
  logic              req;
  logic              wr;
  logic [DW-1:0]     wd;
  logic              reload_buffer_enable_q;
  logic              single_shot_mode_q;
  logic              update_request_source_q;
  logic              update_disable_q;
  logic              counter_enable_bit_q;
  logic [2:0]        master_output_select_q;
  logic              master_slave_sync_q;
  logic [2:0]        trigger_select_q;
  logic [2:0]        slave_mode_select_q;
  logic              trigger_irq_enable_q;
  logic              update_irq_enable_q;
  logic              trigger_flag_q;
  logic              update_flag_q;
  logic [DW-1:0]     cnt_q;
  logic [PSC_SW-1:0] psc_pre_q;
  logic [PSC_SW-1:0] psc_act_q;
  logic [PSC_CW-1:0] psc_cnt_q;
  logic [DW-1:0]     arr_pre_q;
  logic [DW-1:0]     arr_sh_q;
  logic [DW-1:0]     arr_act;
  logic              trg_raw;
  logic              trg_prev_q;
  logic              trg_dly_q;
  logic              trg_eff;
  logic              trg_eff_prev_q;
  logic              trg_rise;
  logic              trg_fall;
  logic              software_update;
  logic              software_trigger;
  logic              wr_cnt;
  logic              wr_cen;
  logic              gated;
  logic              cnt_en;
  logic              psc_in;
  logic              cnt_tick;
  logic              ovf;
  logic              trig_reset;
  logic              trig_reset_q;
  logic              reinit;
  logic              update_event;
  logic              upd_set;
  logic              trg_set;
  logic [DW-1:0]     rd;

  // Bus decode; each register occupies one aligned word
  assign idx    = wb_adr_i[IDX_LO +: IDX_W];
  assign adr_ok = (wb_adr_i[ADR_W-1:IDX_LO+IDX_W] == '0);
  assign req    = wb_cyc_i && wb_stb_i;
  // A write lands on the edge at which the master sees ack
  assign wr     = req && wb_we_i && wb_ack_o && wb_sel_i[0] && adr_ok;
  assign wd     = wb_dat_i[DW-1:0];

  assign software_update  = wr && (idx == IDX_EGR) && wd[B_UPD];
  assign software_trigger = wr && (idx == IDX_EGR) && wd[B_TRG];
  assign wr_cnt           = wr && (idx == IDX_CNT);
  assign wr_cen           = wr && (idx == IDX_CR1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
    end
  end

  always_comb begin
    rd = RST_ZERO;
    unique case (idx)
      IDX_CR1: begin
        rd[B_RELOAD_BUFFER_ENABLE] = reload_buffer_enable_q;
        rd[B_OPM]  = single_shot_mode_q;
        rd[B_URS]  = update_request_source_q;
        rd[B_UPDATE_DISABLE] = update_disable_q;
        rd[B_CEN]  = counter_enable_bit_q;
      end
      IDX_CR2:  rd[F_HI:F_LO] = master_output_select_q;
      IDX_SMCR: begin
        rd[B_MSM]   = master_slave_sync_q;
        rd[F_HI:F_LO] = trigger_select_q;
        rd[S_HI:S_LO] = slave_mode_select_q;
      end
      IDX_IER: begin
        rd[B_TRG] = trigger_irq_enable_q;
        rd[B_UPD] = update_irq_enable_q;
      end
      IDX_SR: begin
        rd[B_TRG] = trigger_flag_q;
        rd[B_UPD] = update_flag_q;
      end
      IDX_CNT:  rd = cnt_q;
      IDX_PSC:  rd[S_HI:S_LO] = psc_pre_q;
      IDX_ARR:  rd = arr_pre_q;
      default:  rd = RST_ZERO;
    endcase
    if (!adr_ok) begin
      rd = RST_ZERO;
    end
  end

  // Read data captured in the request cycle, held through ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_ack_o) begin
      wb_dat_o <= {24'h00_0000, rd};
    end
  end

  // Control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reload_buffer_enable_q  <= 1'b0;
      single_shot_mode_q      <= 1'b0;
      update_request_source_q <= 1'b0;
      update_disable_q        <= 1'b0;
      master_output_select_q  <= RST_FIELD;
      master_slave_sync_q     <= 1'b0;
      trigger_select_q        <= RST_FIELD;
      slave_mode_select_q     <= RST_FIELD;
      trigger_irq_enable_q    <= 1'b0;
      update_irq_enable_q     <= 1'b0;
      psc_pre_q               <= RST_FIELD;
      arr_pre_q               <= RST_ARR;
    end else if (wr) begin
      unique case (idx)
        IDX_CR1: begin
          reload_buffer_enable_q  <= wd[B_RELOAD_BUFFER_ENABLE];
          single_shot_mode_q      <= wd[B_OPM];
          update_request_source_q <= wd[B_URS];
          update_disable_q        <= wd[B_UPDATE_DISABLE];
        end
        IDX_CR2:  master_output_select_q <= wd[F_HI:F_LO];
        IDX_SMCR: begin
          master_slave_sync_q <= wd[B_MSM];
          trigger_select_q    <= wd[F_HI:F_LO];
          slave_mode_select_q <= wd[S_HI:S_LO];
        end
        IDX_IER: begin
          trigger_irq_enable_q <= wd[B_TRG];
          update_irq_enable_q  <= wd[B_UPD];
        end
        IDX_PSC:  psc_pre_q <= wd[S_HI:S_LO];
        IDX_ARR:  arr_pre_q <= wd;
        default: ;
      endcase
    end
  end

  // Trigger input path; reserved selections give a quiet input
  always_comb begin
    unique case (trigger_select_q)
      TS_ITR_ONE: trg_raw = internal_trigger_one_i;
      TS_ITR_THR: trg_raw = internal_trigger_three_i;
      default:    trg_raw = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trg_prev_q     <= 1'b0;
      trg_dly_q      <= 1'b0;
      trg_eff_prev_q <= 1'b0;
    end else begin
      trg_prev_q     <= trg_raw;
      trg_dly_q      <= trg_raw;
      trg_eff_prev_q <= trg_eff;
    end
  end

  // The extra stage lets this timer act in step with the trigger output of its peer
  assign trg_eff  = master_slave_sync_q ? trg_dly_q : trg_raw;
  assign trg_rise = trg_eff && !trg_eff_prev_q;
  assign trg_fall = !trg_eff && trg_eff_prev_q;

  // Slave controller and clock path
  assign gated      = (slave_mode_select_q == SMS_GATED);
  assign cnt_en     = counter_enable_bit_q || (gated && trg_eff);
  assign trig_reset = (slave_mode_select_q == SMS_RESET) && trg_rise;
  always_comb begin
    if (slave_mode_select_q == SMS_EXTCLK) begin
      psc_in = counter_enable_bit_q && trg_rise;
    end else begin
      psc_in = cnt_en;
    end
  end
  assign cnt_tick     = psc_in && (psc_cnt_q == psc_mask(psc_act_q));
  assign arr_act      = reload_buffer_enable_q ? arr_sh_q : arr_pre_q;
  assign ovf          = cnt_tick && (cnt_q == arr_act);
  assign reinit       = software_update || trig_reset;
  assign update_event = (ovf || reinit) && !update_disable_q;
  assign upd_set      = (ovf || (reinit && !update_request_source_q))
                        && !update_disable_q;
  assign trg_set      = software_trigger
                        || (gated && (trg_rise || trg_fall))
                        || (((slave_mode_select_q == SMS_RESET)
                             || (slave_mode_select_q == SMS_TRIG)
                             || (slave_mode_select_q == SMS_EXTCLK)) && trg_rise);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_enable_bit_q <= 1'b0;
    end else if (update_event && single_shot_mode_q) begin
      counter_enable_bit_q <= 1'b0;
    end else if ((slave_mode_select_q == SMS_TRIG) && trg_rise) begin
      counter_enable_bit_q <= 1'b1;
    end else if (wr_cen) begin
      counter_enable_bit_q <= wd[B_CEN];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      psc_cnt_q <= PSC_ZERO;
    end else if (reinit) begin
      psc_cnt_q <= PSC_ZERO;
    end else if (cnt_tick) begin
      psc_cnt_q <= PSC_ZERO;
    end else if (psc_in) begin
      psc_cnt_q <= psc_cnt_q + 7'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= RST_ZERO;
    end else if (wr_cnt) begin
      cnt_q <= wd;
    end else if (reinit) begin
      cnt_q <= RST_ZERO;
    end else if (ovf) begin
      cnt_q <= RST_ZERO;
    end else if (cnt_tick) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // Shadow values move only on an update event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      psc_act_q <= RST_FIELD;
      arr_sh_q  <= RST_ARR;
    end else if (update_event) begin
      psc_act_q <= psc_pre_q;
      arr_sh_q  <= arr_pre_q;
    end
  end

  // Status flags; write 0 clears, a same-cycle hardware set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      update_flag_q  <= 1'b0;
      trigger_flag_q <= 1'b0;
    end else begin
      if (upd_set) begin
        update_flag_q <= 1'b1;
      end else if (wr && (idx == IDX_SR) && !wd[B_UPD]) begin
        update_flag_q <= 1'b0;
      end
      if (trg_set) begin
        trigger_flag_q <= 1'b1;
      end else if (wr && (idx == IDX_SR) && !wd[B_TRG]) begin
        trigger_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      update_irq_o  <= 1'b0;
      trigger_irq_o <= 1'b0;
    end else begin
      update_irq_o  <= update_flag_q && update_irq_enable_q;
      trigger_irq_o <= trigger_flag_q && trigger_irq_enable_q;
    end
  end

  // Trigger output; a trigger-driven reset shows one cycle late
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_reset_q     <= 1'b0;
      trigger_output_o <= 1'b0;
    end else begin
      trig_reset_q <= trig_reset;
      unique case (master_output_select_q)
        MMS_RESET:  trigger_output_o <= software_update || trig_reset_q;
        MMS_ENABLE: trigger_output_o <= counter_enable_bit_q
                                        || (gated && trg_dly_q);
        MMS_UPDATE: trigger_output_o <= update_event;
        default:    trigger_output_o <= 1'b0;
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_wrap;
    ovf && !wr_cnt && !reinit |=> cnt_q == RST_ZERO;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_count;
    cnt_tick && !ovf && !wr_cnt && !reinit |=> cnt_q == $past(cnt_q) + 8'h01;
  endproperty
  a_count: assert property (p_count) else $error("counter did not step");

  property p_psc_bound;
    psc_cnt_q <= psc_mask(psc_act_q) || $changed(psc_act_q);
  endproperty
  a_psc_bound: assert property (p_psc_bound) else $error("prescaler out of range");

  property p_psc_load;
    update_event |=> psc_act_q == $past(psc_pre_q);
  endproperty
  a_psc_load: assert property (p_psc_load) else $error("prescale not loaded");

  property p_psc_hold;
    !update_event |=> $stable(psc_act_q);
  endproperty
  a_psc_hold: assert property (p_psc_hold) else $error("prescale changed early");

  property p_single;
    update_event && single_shot_mode_q |=> !counter_enable_bit_q;
  endproperty
  a_single: assert property (p_single) else $error("single shot kept running");

  property p_urs;
    software_update && (update_request_source_q || update_disable_q) && !update_flag_q
      && !ovf |=> !update_flag_q;
  endproperty
  a_urs: assert property (p_urs) else $error("update flag set by reinit");

  property p_uflag;
    ovf && !update_disable_q |=> update_flag_q ##1 update_flag_q || !update_irq_enable_q
      || update_irq_o;
  endproperty
  a_uflag: assert property (p_uflag) else $error("update flag or request missing");

  property p_ug;
    software_update |=> cnt_q == RST_ZERO && psc_cnt_q == PSC_ZERO;
  endproperty
  a_ug: assert property (p_ug) else $error("software update did not clear");

  property p_halt;
    !counter_enable_bit_q && slave_mode_select_q == SMS_OFF && !wr_cnt && !reinit
      |=> $stable(cnt_q);
  endproperty
  a_halt: assert property (p_halt) else $error("counter moved while disabled");

  property p_trg_flag;
    trg_set |=> trigger_flag_q;
  endproperty
  a_trg_flag: assert property (p_trg_flag) else $error("trigger flag not set");

  property p_trigger_output_upd;
    master_output_select_q == MMS_UPDATE && update_event |=> trigger_output_o;
  endproperty
  a_trigger_output_upd: assert property (p_trigger_output_upd) else $error("update not on trigger output");

  property p_trigger_output_rst;
    master_output_select_q == MMS_RESET && $stable(master_output_select_q) && trig_reset
      |=> ##1 trigger_output_o;
  endproperty
  a_trigger_output_rst: assert property (p_trigger_output_rst) else $error("reset pulse missing");

endmodule : bt8_timer

// >>> verilog/bt8_pkg.sv
// Register map, field layout and mode codes of the 8-bit basic timer
package bt8_pkg;
  localparam int          DW          = 8;
  localparam int          PSC_CW      = 7;
  localparam int          PSC_SW      = 3;
  localparam int          ADR_W       = 8;
  localparam int          IDX_W       = 4;
  localparam int          IDX_LO      = 2;
  // Register indices; byte address is four times the index
  localparam logic [3:0]  IDX_CR1     = 4'h0;
  localparam logic [3:0]  IDX_CR2     = 4'h1;
  localparam logic [3:0]  IDX_SMCR    = 4'h2;
  localparam logic [3:0]  IDX_IER     = 4'h3;
  localparam logic [3:0]  IDX_SR      = 4'h4;
  localparam logic [3:0]  IDX_EGR     = 4'h5;
  localparam logic [3:0]  IDX_CNT     = 4'h6;
  localparam logic [3:0]  IDX_PSC     = 4'h7;
  localparam logic [3:0]  IDX_ARR     = 4'h8;
  // Field positions
  localparam int          B_RELOAD_BUFFER_ENABLE      = 7;
  localparam int          B_OPM       = 3;
  localparam int          B_URS       = 2;
  localparam int          B_UPDATE_DISABLE      = 1;
  localparam int          B_CEN       = 0;
  localparam int          B_MSM       = 7;
  localparam int          F_HI        = 6;
  localparam int          F_LO        = 4;
  localparam int          S_HI        = 2;
  localparam int          S_LO        = 0;
  localparam int          B_TRG       = 6;
  localparam int          B_UPD       = 0;
  // Reset values
  localparam logic [7:0]  RST_ZERO    = 8'h00;
  localparam logic [7:0]  RST_ARR     = 8'hFF;
  localparam logic [2:0]  RST_FIELD   = 3'h0;
  localparam logic [6:0]  PSC_ZERO    = 7'h00;
  // Master output selection codes
  localparam logic [2:0]  MMS_RESET   = 3'h0;
  localparam logic [2:0]  MMS_ENABLE  = 3'h1;
  localparam logic [2:0]  MMS_UPDATE  = 3'h2;
  // Trigger selection codes
  localparam logic [2:0]  TS_ITR_ONE  = 3'h1;
  localparam logic [2:0]  TS_ITR_THR  = 3'h3;
  // Slave mode codes
  localparam logic [2:0]  SMS_OFF     = 3'h0;
  localparam logic [2:0]  SMS_RESET   = 3'h4;
  localparam logic [2:0]  SMS_GATED   = 3'h5;
  localparam logic [2:0]  SMS_TRIG    = 3'h6;
  localparam logic [2:0]  SMS_EXTCLK  = 3'h7;
endpackage : bt8_pkg

// >>> sim/bt8_far_timer.sv
// Model of a neighbouring timer that drives the two trigger lines
`timescale 1ns/10ps
module bt8_far_timer (
  input  wire logic clk_i,
  output logic      trig_one_o,
  output logic      trig_three_o
);
  initial begin
    trig_one_o   = 1'b0;
    trig_three_o = 1'b0;
  end
  // Three low cycles between pulses so edges survive the sync delay
  task automatic pulse(input bit three, input int n, input int hi);
    repeat (n) begin
      @(posedge clk_i);
      if (three) begin
        trig_three_o <= 1'b1;
      end else begin
        trig_one_o <= 1'b1;
      end
      repeat (hi) @(posedge clk_i);
      trig_one_o   <= 1'b0;
      trig_three_o <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
  endtask : pulse
endmodule : bt8_far_timer

// >>> sim/bt8_timer_bench.sv
// Self-checking bench for the 8-bit basic timer
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module bt8_timer_bench;
  import bt8_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, ack, t1, t3, trg, uirq, tirq;
  logic [7:0]  adr, a, v, c1;
  logic [3:0]  sel;
  logic [31:0] dat, rdat;
  int          err_count, cmp_count, n, k;
  int          ix[$] = '{0, 1, 2, 3, 7, 8};
  int          mk[$] = '{8'h8F, 8'h70, 8'hF7, 8'h41, 8'h07, 8'hFF};
  int          rst_val[$] = '{0, 0, 0, 0, 0, 0, 0, 0, 8'hFF, 0};

  bt8_timer uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .internal_trigger_one_i(t1), .internal_trigger_three_i(t3),
    .trigger_output_o(trg), .update_irq_o(uirq), .trigger_irq_o(tirq));
  bt8_far_timer far (.clk_i(clk_i), .trig_one_o(t1), .trig_three_o(t3));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic give_verdict;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  // Waits on ack only; a stuck slave ends the run through the bound
  task automatic wb(input logic w, input logic [3:0] i, input logic [7:0] d,
                    output logic [7:0] q);
    int t;
    t = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {2'b00, i, 2'b00};
    dat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 50);
    if (t >= 50) begin
      err_count++;
      give_verdict();
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, i, d, q);
  endtask : wr

  task automatic chk_rd(input logic [3:0] i, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, i, 8'h00, q);
    `CHK(q, e)
  endtask : chk_rd

  task automatic wait_trg(input int lim, output int t);
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (trg !== 1'b1 && t < lim);
  endtask : wait_trg

  initial begin
    {cyc, stb, we} = '0;
    adr = 8'h00;
    sel = 4'hF;
    dat = 32'h00000000;
    err_count = 0;
    cmp_count = 0;
    rst_i = 1'b1;
    void'($urandom(32'h6FFC));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 10; i++) chk_rd(4'(i), 8'(rst_val[i]));
    wr(4'h9, 8'h5A);
    chk_rd(4'h9, 8'h00);
    foreach (ix[i]) begin
      v = 8'($urandom);
      wr(4'(ix[i]), v);
      chk_rd(4'(ix[i]), v & 8'(mk[i]));
      wr(4'(ix[i]), i == 5 ? 8'hFF : 8'h00);
    end
    $display("register test done");

    wr(IDX_CR2, 8'h20);
    for (int p = 0; p < 8; p++) begin
      a = 8'($urandom_range(7, 1));
      wr(IDX_CR1, 8'h00);
      wr(IDX_PSC, 8'(p));
      wr(IDX_ARR, a);
      wr(IDX_EGR, 8'h01);
      wr(IDX_CR1, 8'h01);
      wait_trg(3000, n);
      wait_trg(3000, n);
      `CHK(n, (int'(a) + 1) << p)
    end
    wr(IDX_CR1, 8'h00);
    wr(IDX_PSC, 8'h00);
    wr(IDX_ARR, 8'h03);
    wr(IDX_EGR, 8'h01);
    wr(IDX_CR1, 8'h09);
    wait_trg(100, n);
    chk_rd(IDX_CR1, 8'h08);
    $display("period test done");

    wr(IDX_CR1, 8'h00);
    wr(IDX_ARR, 8'hFF);
    wr(IDX_IER, 8'h41);
    wr(IDX_SR, 8'h00);
    wr(IDX_EGR, 8'h01);
    chk_rd(IDX_SR, 8'h01);
    `CHK(uirq, 1'b1)
    wr(IDX_SR, 8'h00);
    chk_rd(IDX_SR, 8'h00);
    `CHK(uirq, 1'b0)
    wr(IDX_CR1, 8'h04);
    wr(IDX_EGR, 8'h01);
    chk_rd(IDX_SR, 8'h00);
    wr(IDX_CR1, 8'h02);
    wr(IDX_CNT, 8'h33);
    wr(IDX_EGR, 8'h01);
    chk_rd(IDX_CNT, 8'h00);
    chk_rd(IDX_SR, 8'h00);
    wr(IDX_EGR, 8'h40);
    chk_rd(IDX_SR, 8'h40);
    `CHK(tirq, 1'b1)
    chk_rd(IDX_EGR, 8'h00);
    $display("flag test done");

    wr(IDX_CR1, 8'h00);
    wr(IDX_SMCR, 8'h10);
    k = int'($urandom_range(1, 0));
    wr(IDX_SMCR, {k[0], 7'h17});
    wr(IDX_CNT, 8'h00);
    wr(IDX_SR, 8'h00);
    wr(IDX_CR1, 8'h01);
    n = int'($urandom_range(9, 3));
    far.pulse(1'b0, n, 2);
    chk_rd(IDX_CNT, 8'(n));
    chk_rd(IDX_SR, 8'h40);
    wr(IDX_CR2, 8'h10);
    repeat (3) @(posedge clk_i);
    `CHK(trg, 1'b1)
    wr(IDX_CR1, 8'h00);
    wr(IDX_SMCR, 8'h15);
    wr(IDX_CNT, 8'h00);
    far.pulse(1'b0, 1, 20);
    wb(1'b0, IDX_CNT, 8'h00, c1);
    chk_rd(IDX_CNT, c1);
    `CHK(c1 >= 8'd18 && c1 <= 8'd22, 1'b1)
    wr(IDX_CR1, 8'h00);
    wr(IDX_SMCR, 8'h30);
    wr(IDX_SMCR, 8'h34);
    wr(IDX_CNT, 8'h50);
    wr(IDX_SR, 8'h00);
    far.pulse(1'b1, 1, 2);
    chk_rd(IDX_CNT, 8'h00);
    chk_rd(IDX_SR, 8'h41);
    wr(IDX_SMCR, 8'h36);
    far.pulse(1'b1, 1, 2);
    chk_rd(IDX_CR1, 8'h01);
    $display("slave test done");

    wr(IDX_CR1, 8'h00);
    wr(IDX_SMCR, 8'h00);
    wr(IDX_CR2, 8'h00);
    wr(IDX_EGR, 8'h01);
    wait_trg(4, n);
    `CHK(n < 4, 1'b1)
    wr(IDX_CR2, 8'h30);
    wr(IDX_EGR, 8'h01);
    wait_trg(6, n);
    `CHK(n, 6)
    $display("master output test done");
    give_verdict();
  end
endmodule : bt8_timer_bench
